/* hw/pmc_pkg.sv */
// constants and types shared by the parallel port mode control block
package pmc_pkg;
	localparam int BUS_AW = 8;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 15;
	localparam int SYNC_W = 13;
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	localparam int BUSY_BIT = 15;
	localparam int INTERRUPT_REQUEST_SELECT_LO = 13;
	localparam int ADDRESS_STEP_SELECT_LO = 11;
	localparam int UNIMP_BIT = 10;
	localparam int MODE_LO = 8;
	localparam int SETUP_WAIT_STATES_LO = 6;
	localparam int STROBE_WAIT_STATES_LO = 2;
	localparam int END_WAIT_STATES_LO = 0;
	localparam logic [31:0] MODE_RST = 32'h0000_0000;
	localparam logic [31:0] MODE_WMASK = 32'h0000_7BFF;
	localparam logic [1:0] IRQ_NONE = 2'h0;
	localparam logic [1:0] IRQ_EACH = 2'h1;
	localparam logic [1:0] IRQ_BUF3 = 2'h2;
	localparam logic [1:0] STEP_NONE = 2'h0;
	localparam logic [1:0] STEP_INC = 2'h1;
	localparam logic [1:0] STEP_DEC = 2'h2;
	localparam logic [1:0] STEP_BUF = 2'h3;
	localparam logic [1:0] PM_LEGACY = 2'h0;
	localparam logic [1:0] PM_ENH = 2'h1;
	localparam logic [1:0] PM_MAST2 = 2'h2;
	localparam logic [1:0] PM_MAST1 = 2'h3;
	localparam int CTRL_CS1_BIT = 0;
	localparam int CTRL_RD_BIT = 1;
	localparam int STAT_W = 2;
	localparam int STAT_REQ_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int A14 = 14;
	localparam int STEP_HI = 10;
	localparam int STEP_LO = 2;
	localparam logic [1:0] LAST_BUF = 2'h3;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SETUP = 4'b0010,
		ST_STROBE = 4'b0100,
		ST_END = 4'b1000
	} pmc_state_e;
endpackage : pmc_pkg

/* hw/pmc_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module pmc_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule : pmc_sync

/* hw/pmc_top.sv */
// parallel port mode control: mode register, master cycle timing, slave buffers
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module pmc_top
	import pmc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [pmc_pkg::BUS_AW-1:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	output logic irq,
	input wire logic chip_select_one_in,
	output logic chip_select_one_out,
	output logic chip_select_one_oe,
	input wire logic read_strobe_in,
	output logic read_strobe_out,
	output logic read_strobe_oe,
	input wire logic write_strobe_in,
	output logic write_strobe_out,
	output logic write_strobe_oe,
	input wire logic [1:0] port_address_in,
	output logic [pmc_pkg::ADDR_W-1:0] port_address_out,
	output logic port_address_oe,
	input wire logic [pmc_pkg::DATA_W-1:0] port_data_in,
	output logic [pmc_pkg::DATA_W-1:0] port_data_out,
	output logic port_data_oe
);
	import pmc_pkg::*;

	function automatic logic [4:0] setup_len(input logic [3:0] wm, input logic [1:0] wb);
		setup_len = (wm == 4'h0) ? 5'h01 : {3'h0, wb} + 5'h01;
	endfunction : setup_len

	function automatic logic [4:0] end_len(input logic [3:0] wm, input logic [1:0] we,
		input logic is_rd);
		if (wm == 4'h0) begin
			end_len = is_rd ? 5'h00 : 5'h01;
		end else begin
			end_len = {3'h0, we} + 5'h01;
		end
	endfunction : end_len

	function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
		input logic dec, input logic keep14);
		logic [8:0] lo;
		logic [9:0] wide;
		lo = dec ? a[STEP_HI:STEP_LO] - 9'h001 : a[STEP_HI:STEP_LO] + 9'h001;
		wide = dec ? {a[A14], a[STEP_HI:STEP_LO]} - 10'h001
			: {a[A14], a[STEP_HI:STEP_LO]} + 10'h001;
		step_addr = a;
		if (keep14) begin
			step_addr[STEP_HI:STEP_LO] = lo;
		end else begin
			{step_addr[A14], step_addr[STEP_HI:STEP_LO]} = wide;
		end
	endfunction : step_addr

	logic [31:0] mode_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [DATA_W-1:0] wdata_ff;
	logic [DATA_W-1:0] mdata_ff;
	logic cs1_en_ff;
	logic [STAT_W-1:0] stat_ff;
	logic [STAT_W-1:0] mask_ff;
	pmc_state_e st_ff;
	pmc_state_e nxt_st;
	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic dir_rd_ff;
	logic [3:0] span_ff;
	logic [DATA_W-1:0] rbuf [4];
	logic [DATA_W-1:0] wbuf [4];
	logic [1:0] rptr_ff;
	logic [1:0] wptr_ff;
	logic [SYNC_W-1:0] pin_sync;
	logic s_cs, s_rd, s_wr;
	logic [1:0] s_a;
	logic [DATA_W-1:0] s_d;
	logic cs_q_ff, rd_q_ff, wr_q_ff;
	logic [1:0] interrupt_request_select, address_step_select, pmode, setup_wait_states, end_wait_states;
	logic [3:0] strobe_wait_states;
	logic is_master, busy, start, start_rd, cycle_done;
	logic acc_rd, acc_wr, slave_acc, buf_mode;
	logic [1:0] ridx, widx, acc_idx, sw_idx;
	logic req_evt, addr_wr;
	logic [4:0] end_n;
	logic [1:0] cap_ff;

	assign interrupt_request_select = mode_ff[INTERRUPT_REQUEST_SELECT_LO +: 2];
	assign address_step_select = mode_ff[ADDRESS_STEP_SELECT_LO +: 2];
	assign pmode = mode_ff[MODE_LO +: 2];
	assign setup_wait_states = mode_ff[SETUP_WAIT_STATES_LO +: 2];
	assign strobe_wait_states = mode_ff[STROBE_WAIT_STATES_LO +: 4];
	assign end_wait_states = mode_ff[END_WAIT_STATES_LO +: 2];
	assign is_master = pmode[1];
	assign busy = (st_ff != ST_IDLE);
	assign addr_wr = bus_wr && (bus_addr == OFS_ADDR);
	assign sw_idx = addr_ff[1:0];

	// master cycles are started only from idle; requests while busy are dropped
	assign start_rd = bus_wr && (bus_addr == OFS_CTRL) && bus_wdata[CTRL_RD_BIT];
	assign start = is_master && !busy && (start_rd || (bus_wr && bus_addr == OFS_DATA));
	assign end_n = end_len(strobe_wait_states, end_wait_states, dir_rd_ff);

	// registers written by software
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mode_ff <= MODE_RST;
			cs1_en_ff <= 1'b0;
			mask_ff <= '0;
			wdata_ff <= '0;
		end else if (bus_wr) begin
			if (bus_addr == OFS_MODE) begin
				mode_ff <= bus_wdata & MODE_WMASK;
			end else if (bus_addr == OFS_CTRL) begin
				cs1_en_ff <= bus_wdata[CTRL_CS1_BIT];
			end else if (bus_addr == OFS_MASK) begin
				mask_ff <= bus_wdata[STAT_W-1:0];
			end else if (bus_addr == OFS_DATA && is_master && !busy) begin
				wdata_ff <= bus_wdata[DATA_W-1:0];
			end
		end
	end

	// address register and automatic step
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			addr_ff <= '0;
		end else if (addr_wr) begin
			addr_ff <= bus_wdata[ADDR_W-1:0];
		end else if (cycle_done) begin
			if (address_step_select == STEP_INC || address_step_select == STEP_DEC) begin
				addr_ff <= step_addr(addr_ff, address_step_select == STEP_DEC, cs1_en_ff);
			end
		end
	end

	// master cycle sequencer
	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		cycle_done = 1'b0;
		case (st_ff)
			ST_IDLE: begin
				if (start) begin
					nxt_st = ST_SETUP;
					nxt_cnt = 4'(setup_len(strobe_wait_states, setup_wait_states) - 5'h01);
				end
			end
			ST_SETUP: begin
				if (cnt_ff == 4'h0) begin
					nxt_st = ST_STROBE;
					nxt_cnt = strobe_wait_states;
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
			end
			ST_STROBE: begin
				if (cnt_ff != 4'h0) begin
					nxt_cnt = cnt_ff - 4'h1;
				end else if (end_n == 5'h00) begin
					// no end phase on short read
					nxt_st = ST_IDLE;
					cycle_done = 1'b1;
				end else begin
					nxt_st = ST_END;
					nxt_cnt = 4'(end_n - 5'h01);
				end
			end
			ST_END: begin
				if (cnt_ff == 4'h0) begin
					nxt_st = ST_IDLE;
					cycle_done = 1'b1;
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_ff <= ST_IDLE;
			cnt_ff <= 4'h0;
			dir_rd_ff <= 1'b0;
			span_ff <= 4'h0;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			span_ff <= (nxt_st != st_ff) ? 4'h0 : span_ff + 4'h1;
			if (start) begin
				dir_rd_ff <= start_rd;
			end
		end
	end

	// pins lag two cycles through sync, so capture trails the strobe's last period
	// limitation: data lands two cycles after the done flag on a short read
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cap_ff <= 2'h0;
			mdata_ff <= '0;
		end else begin
			cap_ff <= {cap_ff[0], st_ff == ST_STROBE && cnt_ff == 4'h0 && dir_rd_ff};
			if (cap_ff[1]) begin
				mdata_ff <= s_d;
			end
		end
	end

	// slave pins pass the synchroniser before any use
	pmc_sync #(.W(SYNC_W)) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.d({chip_select_one_in, read_strobe_in, write_strobe_in, port_address_in, port_data_in}),
		.q(pin_sync)
	);
	assign {s_cs, s_rd, s_wr, s_a, s_d} = pin_sync;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cs_q_ff <= 1'b0;
			rd_q_ff <= 1'b0;
			wr_q_ff <= 1'b0;
		end else begin
			cs_q_ff <= s_cs;
			rd_q_ff <= s_rd;
			wr_q_ff <= s_wr;
		end
	end

	// an access completes when its strobe falls while selected
	assign acc_rd = !is_master && cs_q_ff && rd_q_ff && !s_rd;
	assign acc_wr = !is_master && cs_q_ff && wr_q_ff && !s_wr;
	assign slave_acc = acc_rd || acc_wr;
	// buffer advance only in legacy slave mode
	assign buf_mode = (pmode == PM_LEGACY) && (address_step_select == STEP_BUF);
	assign ridx = (pmode == PM_ENH) ? s_a : (buf_mode ? rptr_ff : 2'h0);
	assign widx = (pmode == PM_ENH) ? s_a : (buf_mode ? wptr_ff : 2'h0);
	assign acc_idx = acc_rd ? ridx : widx;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rptr_ff <= 2'h0;
			wptr_ff <= 2'h0;
		end else if (!buf_mode) begin
			rptr_ff <= 2'h0;
			wptr_ff <= 2'h0;
		end else begin
			if (acc_rd) begin
				rptr_ff <= rptr_ff + 2'h1;
			end
			if (acc_wr) begin
				wptr_ff <= wptr_ff + 2'h1;
			end
		end
	end

	// buffers have no reset; software loads read buffers before use
	always_ff @(posedge sys_clk) begin
		if (acc_wr) begin
			wbuf[widx] <= s_d;
		end
		if (bus_wr && bus_addr == OFS_DATA && !is_master) begin
			rbuf[sw_idx] <= bus_wdata[DATA_W-1:0];
		end
	end

	assign req_evt = (interrupt_request_select == IRQ_EACH && (cycle_done || slave_acc))
		|| (interrupt_request_select == IRQ_BUF3 && slave_acc && acc_idx == LAST_BUF);

	// status flags: a set in the clearing cycle wins
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stat_ff <= '0;
			irq <= 1'b0;
		end else begin
			stat_ff[STAT_REQ_BIT] <= req_evt || (stat_ff[STAT_REQ_BIT]
				&& !(bus_wr && bus_addr == OFS_STAT && bus_wdata[STAT_REQ_BIT]));
			stat_ff[STAT_DONE_BIT] <= cycle_done || (stat_ff[STAT_DONE_BIT]
				&& !(bus_wr && bus_addr == OFS_STAT && bus_wdata[STAT_DONE_BIT]));
			irq <= |(stat_ff & mask_ff);
		end
	end

	// register read port, data valid only in the cycle after the strobe
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bus_rdata <= 32'h0000_0000;
		end else if (!bus_rd) begin
			bus_rdata <= 32'h0000_0000;
		end else if (bus_addr == OFS_MODE) begin
			bus_rdata <= {16'h0000, busy && is_master, mode_ff[BUSY_BIT-1:0]};
		end else if (bus_addr == OFS_ADDR) begin
			bus_rdata <= {17'h0_0000, addr_ff};
		end else if (bus_addr == OFS_DATA) begin
			bus_rdata <= {24'h00_0000, is_master ? mdata_ff : wbuf[sw_idx]};
		end else if (bus_addr == OFS_CTRL) begin
			bus_rdata <= {31'h0000_0000, cs1_en_ff};
		end else if (bus_addr == OFS_STAT) begin
			bus_rdata <= {30'h0000_0000, stat_ff};
		end else if (bus_addr == OFS_MASK) begin
			bus_rdata <= {30'h0000_0000, mask_ff};
		end else begin
			bus_rdata <= 32'h0000_0000;
		end
	end

	// pin drivers, all registered
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			chip_select_one_out <= 1'b0;
			read_strobe_out <= 1'b0;
			write_strobe_out <= 1'b0;
			port_address_out <= '0;
			port_data_out <= '0;
			port_data_oe <= 1'b0;
		end else begin
			chip_select_one_out <= nxt_st != ST_IDLE;
			if (pmode == PM_MAST1) begin
				read_strobe_out <= (nxt_st == ST_IDLE) ? 1'b0 : (start ? start_rd : dir_rd_ff);
				write_strobe_out <= nxt_st == ST_STROBE;
			end else begin
				read_strobe_out <= nxt_st == ST_STROBE && dir_rd_ff;
				write_strobe_out <= nxt_st == ST_STROBE && !dir_rd_ff;
			end
			port_address_out <= addr_ff;
			if (cs1_en_ff) begin
				// bit 14 serves as chip select
				port_address_out[A14] <= nxt_st != ST_IDLE;
			end
			if (is_master) begin
				port_data_out <= wdata_ff;
				port_data_oe <= nxt_st != ST_IDLE && !(start ? start_rd : dir_rd_ff);
			end else begin
				port_data_out <= rbuf[ridx];
				port_data_oe <= s_cs && s_rd;
			end
		end
	end

	// strobe and select pins are outputs only in master modes
	assign chip_select_one_oe = is_master;
	assign read_strobe_oe = is_master;
	assign write_strobe_oe = is_master;
	assign port_address_oe = is_master;

	busy_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
		(bus_rd && bus_addr == OFS_MODE && is_master) |=> bus_rdata[BUSY_BIT] == $past(busy))
		else $error("busy bit does not follow transfer state");
	irq_none_a: assert property (@(posedge sys_clk) disable iff (rst)
		(interrupt_request_select == IRQ_NONE && !stat_ff[STAT_REQ_BIT]) |=> !stat_ff[STAT_REQ_BIT])
		else $error("request flag set with requests off");
	irq_each_a: assert property (@(posedge sys_clk) disable iff (rst)
		(interrupt_request_select == IRQ_EACH && cycle_done) |=> stat_ff[STAT_REQ_BIT] ##1 irq || !mask_ff[0])
		else $error("no request after cycle end");
	irq_buf3_a: assert property (@(posedge sys_clk) disable iff (rst)
		(interrupt_request_select == IRQ_BUF3 && slave_acc && acc_idx == LAST_BUF) |=> stat_ff[STAT_REQ_BIT])
		else $error("no request on buffer 3 access");
	addr_inc_a: assert property (@(posedge sys_clk) disable iff (rst)
		(cycle_done && address_step_select == STEP_INC && !cs1_en_ff && !addr_wr) |=>
		{addr_ff[A14], addr_ff[STEP_HI:STEP_LO]}
		== 10'($past({addr_ff[A14], addr_ff[STEP_HI:STEP_LO]}) + 10'h001))
		else $error("address not incremented");
	addr_dec_a: assert property (@(posedge sys_clk) disable iff (rst)
		(cycle_done && address_step_select == STEP_DEC && !cs1_en_ff && !addr_wr) |=>
		{addr_ff[A14], addr_ff[STEP_HI:STEP_LO]}
		== 10'($past({addr_ff[A14], addr_ff[STEP_HI:STEP_LO]}) - 10'h001))
		else $error("address not decremented");
	addr_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		(address_step_select == STEP_NONE && !addr_wr) |=> $stable(addr_ff))
		else $error("address moved with stepping off");
	a14_fixed_a: assert property (@(posedge sys_clk) disable iff (rst)
		(cycle_done && cs1_en_ff && !addr_wr) |=> addr_ff[A14] == $past(addr_ff[A14]))
		else $error("chip select bit was stepped");
	setup_len_a: assert property (@(posedge sys_clk) disable iff (rst)
		(st_ff == ST_SETUP && nxt_st == ST_STROBE && strobe_wait_states != 4'h0)
		|-> span_ff == {2'h0, setup_wait_states})
		else $error("setup phase length wrong");
	short_rd_a: assert property (@(posedge sys_clk) disable iff (rst)
		(start && start_rd && strobe_wait_states == 4'h0) ##1 (st_ff == ST_SETUP && strobe_wait_states == 4'h0) |=>
		st_ff == ST_STROBE ##1 st_ff == ST_IDLE)
		else $error("short read timing wrong");
	short_wr_a: assert property (@(posedge sys_clk) disable iff (rst)
		(start && !start_rd && strobe_wait_states == 4'h0) ##1 (strobe_wait_states == 4'h0) |=>
		st_ff == ST_STROBE ##1 st_ff == ST_END ##1 st_ff == ST_IDLE)
		else $error("short write timing wrong");
	unimp_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		(bus_rd && bus_addr == OFS_MODE) |=> bus_rdata[31:16] == 16'h0000
		&& !bus_rdata[UNIMP_BIT])
		else $error("unimplemented mode bits not zero");
endmodule : pmc_top

/* verification/pmc_periph.sv */
// far-side parallel peripheral: byte memory plus host data driver
`timescale 1ns/1ns
module pmc_periph (
	input wire logic sys_clk,
	input wire logic cs_drv,
	input wire logic cs,
	input wire logic wstb,
	input wire logic [14:0] addr,
	input wire logic [7:0] dout,
	input wire logic doe,
	input wire logic host_drv,
	input wire logic [7:0] host_d,
	output logic [7:0] pin_d
);
	logic [7:0] mem [256];
	logic [7:0] last_ff = 8'h00;
	logic wstb_ff = 1'b0;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5A;
		end
	end
	always @(posedge sys_clk) begin
		wstb_ff <= wstb;
		if (wstb_ff && !wstb && doe) begin
			mem[addr[7:0]] <= dout;
		end
		last_ff <= pin_d;
	end
	// selected read drives byte
	// released bus toggles so stale data never matches by luck
	always_comb begin
		if (cs_drv && cs && !doe) begin
			pin_d = mem[addr[7:0]];
		end else if (host_drv) begin
			pin_d = host_d;
		end else begin
			pin_d = ~last_ff;
		end
	end
endmodule : pmc_periph

/* verification/test_pmc_top.sv */
// self-checking bench for the parallel port mode control block
`timescale 1ns/1ns
module test_pmc_top;
	import pmc_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [BUS_AW-1:0] bus_addr = '0;
	logic [31:0] bus_wdata = '0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [31:0] bus_rdata;
	logic [31:0] rv;
	logic irq, cs_out, cs_oe, rs_out, rs_oe, ws_out, ws_oe, a_oe, d_oe;
	logic [ADDR_W-1:0] a_out;
	logic [DATA_W-1:0] d_out, d_in;
	logic h_cs = 1'b0;
	logic h_rd = 1'b0;
	logic h_wr = 1'b0;
	logic h_drv = 1'b0;
	logic [1:0] h_a = 2'h0;
	logic [7:0] h_d = 8'h00;
	logic msk = 1'b0;
	int n_mismatch = 0;
	int samples_checked = 0;
	int n_cs = 0;
	int n_we = 0;
	int n_re = 0;
	int cyc = 0;

	pmc_top u_dut (
		.sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
		.chip_select_one_in(cs_oe ? cs_out : h_cs), .chip_select_one_out(cs_out),
		.chip_select_one_oe(cs_oe), .read_strobe_in(rs_oe ? rs_out : h_rd),
		.read_strobe_out(rs_out), .read_strobe_oe(rs_oe),
		.write_strobe_in(ws_oe ? ws_out : h_wr), .write_strobe_out(ws_out),
		.write_strobe_oe(ws_oe), .port_address_in(h_a), .port_address_out(a_out),
		.port_address_oe(a_oe), .port_data_in(d_in), .port_data_out(d_out),
		.port_data_oe(d_oe)
	);
	pmc_periph u_per (
		.sys_clk(sys_clk), .cs_drv(cs_oe), .cs(cs_out), .wstb(ws_out), .addr(a_out),
		.dout(d_out), .doe(d_oe), .host_drv(h_drv), .host_d(h_d), .pin_d(d_in)
	);

	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	// phase counters and hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		n_cs <= n_cs + int'(cs_out);
		n_we <= n_we + int'(ws_out);
		n_re <= n_re + int'(rs_out);
		if (cyc == 20000) begin
			n_mismatch++;
			final_report();
		end
	end

	task automatic final_report();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
	endtask : wr

	task automatic rd_q(input logic [7:0] a);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		@(negedge sys_clk);
		rv = bus_rdata;
	endtask : rd_q

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		rd_q(a);
		chk(rv, exp);
	endtask : rd

	function automatic logic [31:0] mw(input logic [1:0] iq, input logic [1:0] st,
		input logic [1:0] pm, input logic [7:0] lo);
		mw = (32'(iq) << INTERRUPT_REQUEST_SELECT_LO) | (32'(st) << ADDRESS_STEP_SELECT_LO) | (32'(pm) << MODE_LO) | 32'(lo);
	endfunction : mw

	// one master cycle; phase lengths, address step and request checked after it
	task automatic op(input logic [31:0] mode, input logic cs1, input logic is_rd,
		input logic [14:0] a0, input logic [14:0] a1, input int ecs, input int ewe,
		input int ere);
		logic [1:0] est;
		est = {1'b1, mode[INTERRUPT_REQUEST_SELECT_LO+:2] == IRQ_EACH};
		wr(OFS_MODE, mode);
		wr(OFS_ADDR, 32'(a0));
		wr(OFS_CTRL, {31'h0, cs1});
		@(negedge sys_clk);
		n_cs = 0;
		n_we = 0;
		n_re = 0;
		if (is_rd) begin
			wr(OFS_CTRL, {30'h0, 1'b1, cs1});
		end else begin
			wr(OFS_DATA, {24'h0, 8'hA5 ^ mode[7:0]});
		end
		if (ecs > 5) begin
			rd(OFS_MODE, mode | 32'h0000_8000); // busy while running
		end
		repeat (40) begin
			rd_q(OFS_STAT);
			if (rv[STAT_DONE_BIT] === 1'b1) break;
		end
		chk(n_cs, ecs);
		chk(n_we, ewe);
		chk(n_re, ere);
		chk({a_oe, cs_oe, rs_oe, ws_oe}, 4'hF);
		if (is_rd) begin
			rd(OFS_DATA, {24'h0, a0[7:0] ^ 8'h5A});
		end else begin
			chk(u_per.mem[a0[7:0]], 8'hA5 ^ mode[7:0]);
		end
		rd(OFS_ADDR, 32'(a1));
		rd(OFS_STAT, 32'(est)); // request per select
		chk(irq, est[0] & msk);
		wr(OFS_STAT, 32'h3);
		rd(OFS_STAT, 32'h0);
		chk(irq, 1'b0);
	endtask : op

	task automatic hw(input logic [1:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		h_cs <= 1'b1;
		h_a <= a;
		h_d <= d;
		h_drv <= 1'b1;
		repeat (3) @(posedge sys_clk);
		h_wr <= 1'b1;
		repeat (4) @(posedge sys_clk);
		h_wr <= 1'b0;
		repeat (4) @(posedge sys_clk);
		h_cs <= 1'b0;
		h_drv <= 1'b0;
	endtask : hw

	// host read: pin data and enable taken mid-cycle while the host holds the strobe
	task automatic hrd(input logic [1:0] a);
		@(posedge sys_clk);
		h_cs <= 1'b1;
		h_a <= a;
		h_rd <= 1'b1;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		rv = {23'h0, d_oe, d_out};
		@(posedge sys_clk);
		h_rd <= 1'b0;
		repeat (4) @(posedge sys_clk);
		h_cs <= 1'b0;
	endtask : hrd

	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		rd(OFS_MODE, 32'h0); // reset value
		wr(OFS_MODE, 32'hFFFF_FFFF);
		rd(OFS_MODE, 32'h0000_7BFF); // unwritable bits
		rd(8'h3C, 32'h0);
		wr(OFS_MASK, 32'h1);
		msk = 1'b1;
		op(mw(IRQ_EACH, STEP_INC, PM_MAST2, 8'h00), 0, 0, 15'h07FC, 15'h4000, 3, 1, 0);
		op(mw(IRQ_EACH, STEP_DEC, PM_MAST2, 8'h00), 0, 1, 15'h4000, 15'h07FC, 2, 0, 1);
		op(mw(IRQ_NONE, STEP_NONE, PM_MAST2, 8'hC9), 0, 0, 15'h0123, 15'h0123, 9, 3, 0);
		op(mw(IRQ_EACH, STEP_INC, PM_MAST2, 8'hC1), 1, 0, 15'h07FC, 15'h0000, 3, 1, 0);
		wr(OFS_MASK, 32'h0);
		msk = 1'b0;
		op(mw(IRQ_EACH, STEP_DEC, PM_MAST1, 8'h00), 0, 1, 15'h0010, 15'h000C, 2, 1, 2);
		wr(OFS_MASK, 32'h1);
		msk = 1'b1;
		op(mw(IRQ_EACH, STEP_NONE, PM_MAST1, 8'h06), 0, 1, 15'h0020, 15'h0020, 6, 2, 6);
		wr(OFS_MODE, mw(IRQ_BUF3, STEP_NONE, PM_ENH, 8'h00));
		hw(2'h1, 8'h11);
		rd(OFS_STAT, 32'h0); // other address quiet
		chk({cs_oe, a_oe, d_oe, rs_oe, ws_oe}, 5'h00); // host owns pins
		hw(2'h3, 8'h3C);
		rd(OFS_STAT, 32'h1); // address 3 request
		chk(irq, 1'b1); // level output
		wr(OFS_STAT, 32'h3);
		wr(OFS_ADDR, 32'h3);
		rd(OFS_DATA, 32'h3C); // addressed buffer
		wr(OFS_ADDR, 32'h1);
		rd(OFS_DATA, 32'h11); // addressed buffer
		wr(OFS_ADDR, 32'h2);
		wr(OFS_DATA, 32'h5C);
		hrd(2'h2);
		chk(rv, 32'h0000_015C); // host reads loaded buffer
		rd(OFS_STAT, 32'h0); // index 2 quiet
		wr(OFS_MODE, mw(IRQ_NONE, STEP_BUF, PM_LEGACY, 8'h00));
		hw(2'h0, 8'h77);
		hw(2'h0, 8'h88);
		wr(OFS_ADDR, 32'h0);
		rd(OFS_DATA, 32'h77); // first buffer
		wr(OFS_ADDR, 32'h1);
		rd(OFS_DATA, 32'h88); // buffer advanced
		final_report();
	end
endmodule : test_pmc_top
